// file: design/laboe_params.svh
// opcode fields, encodings and reset values for the literal/bit execute unit
// assumes: included by the package and the execute module
`ifndef LABOE_PARAMS_SVH
`define LABOE_PARAMS_SVH
`define LABOE_OP_W 14
`define LABOE_LIT_MSB 7
`define LABOE_FADDR_MSB 6
`define LABOE_DEST_BIT 7
`define LABOE_BIT_MSB 9
`define LABOE_BIT_LSB 7
`define LABOE_OP6_MSB 13
`define LABOE_OP6_LSB 8
`define LABOE_OP5_LSB 9
`define LABOE_OP4_LSB 10
`define LABOE_ADD_LIT_5 5'h1f
`define LABOE_AND_LIT_6 6'h39
`define LABOE_ADD_REG_6 6'h07
`define LABOE_AND_REG_6 6'h05
`define LABOE_BCLR_4 4'h4
`define LABOE_BTST_4 4'h6
`define LABOE_NOP_WORD 14'h0000
`define LABOE_ACC_RST 8'h00
`endif

// file: design/laboe_pkg.sv
// types for the literal/bit execute unit
// assumes: laboe_params.svh on the include path
`include "laboe_params.svh"
package laboe_pkg;
    typedef struct packed {
        logic arith_overflow_bit;
        logic nibble_overflow_bit;
        logic null_result_bit;
    } laboe_flags_t;
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } laboe_fwrite_t;
    typedef enum logic [0:0] {
        LABOE_RUN = 1'b0,
        LABOE_FLUSH = 1'b1
    } laboe_state_t;
endpackage : laboe_pkg

// file: design/laboe_exec.sv
// execute unit: literal add/and, register add/and, bit clear, bit test-skip
// assumes: the core presents one fetched word per cycle on instr with instr_valid,
// reads the file register at instr address combinationally on freg_rdata,
// and applies freg_wr one cycle later; flags are held here and exported.
// Operation
// - opcode 11111x adds literal to accumulator, updates all three flags
// - opcode 111001 ands literal with accumulator, updates only null flag
// - opcode 000101 ands accumulator with file register, null flag only, one cycle
// - destination bit 0 writes accumulator, 1 writes file; register add sets all flags
// - opcode 0100 clears selected bit in file register, flags unchanged
// - opcode 0110 skips next instruction when selected bit is zero, flags unchanged
// - taken skip discards prefetched word and runs a no-op cycle instead
`timescale 1ns/1ps
`include "laboe_params.svh"
module laboe_exec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [`LABOE_OP_W-1:0] instr,
    input wire logic [7:0] freg_rdata,
    output logic [7:0] acc,
    output laboe_pkg::laboe_flags_t flags,
    output laboe_pkg::laboe_fwrite_t freg_wr,
    output logic [`LABOE_FADDR_MSB:0] freg_raddr,
    output logic skip_active,
    output logic instr_done
);
    function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] lo;
        logic [8:0] full;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        full = {1'b0, a} + {1'b0, b};
        add8 = {full[8], lo[4], full[7:0]};
    endfunction : add8

    laboe_pkg::laboe_state_t state_r, state_nxt;
    logic [7:0] acc_r, acc_nxt;
    laboe_pkg::laboe_flags_t flags_r, flags_nxt;
    laboe_pkg::laboe_fwrite_t fwr_r, fwr_nxt;

    wire logic [7:0] lit = instr[`LABOE_LIT_MSB:0];
    wire logic [6:0] faddr = instr[`LABOE_FADDR_MSB:0];
    wire logic dest_f = instr[`LABOE_DEST_BIT];
    wire logic [2:0] bsel = instr[`LABOE_BIT_MSB:`LABOE_BIT_LSB];
    wire logic [5:0] op6 = instr[`LABOE_OP6_MSB:`LABOE_OP6_LSB];
    wire logic [4:0] op5 = instr[`LABOE_OP6_MSB:`LABOE_OP5_LSB];
    wire logic [3:0] op4 = instr[`LABOE_OP6_MSB:`LABOE_OP4_LSB];
    // flush cycle turns whatever was fetched into a no-op
    wire logic live = instr_valid && (state_r == laboe_pkg::LABOE_RUN);
    // literal add ignores bit 8, so both encodings of it land here
    wire logic is_lit_add = live && (op5 == `LABOE_ADD_LIT_5);
    wire logic is_lit_and = live && (op6 == `LABOE_AND_LIT_6);
    wire logic is_reg_add = live && (op6 == `LABOE_ADD_REG_6);
    wire logic is_reg_and = live && (op6 == `LABOE_AND_REG_6);
    wire logic is_bclr = live && (op4 == `LABOE_BCLR_4);
    wire logic is_btst = live && (op4 == `LABOE_BTST_4);
    wire logic [7:0] bmask = 8'h01 << bsel;
    wire logic take_skip = is_btst && ((freg_rdata & bmask) == 8'h00);
    wire logic [9:0] sum_lit = add8(acc_r, lit);
    wire logic [9:0] sum_reg = add8(acc_r, freg_rdata);
    wire logic [7:0] and_lit = acc_r & lit;
    wire logic [7:0] and_reg = acc_r & freg_rdata;

    always_comb begin
        acc_nxt = acc_r;
        flags_nxt = flags_r;
        fwr_nxt = '0;
        state_nxt = laboe_pkg::LABOE_RUN;
        // opcodes are disjoint, so the priority order costs nothing
        if (is_lit_add) begin
            acc_nxt = sum_lit[7:0];
            flags_nxt = {sum_lit[9], sum_lit[8], sum_lit[7:0] == 8'h00};
        end else if (is_lit_and) begin
            acc_nxt = and_lit;
            flags_nxt.null_result_bit = (and_lit == 8'h00);
        end else if (is_reg_add) begin
            flags_nxt = {sum_reg[9], sum_reg[8], sum_reg[7:0] == 8'h00};
            if (dest_f) begin
                fwr_nxt = {1'b1, faddr, sum_reg[7:0]};
            end else begin
                acc_nxt = sum_reg[7:0];
            end
        end else if (is_reg_and) begin
            flags_nxt.null_result_bit = (and_reg == 8'h00);
            if (dest_f) begin
                fwr_nxt = {1'b1, faddr, and_reg};
            end else begin
                acc_nxt = and_reg;
            end
        end else if (is_bclr) begin
            fwr_nxt = {1'b1, faddr, freg_rdata & ~bmask};
        end else if (take_skip) begin
            state_nxt = laboe_pkg::LABOE_FLUSH;
        end
    end

    // synchronous reset only; core holds instr_valid low until ready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= laboe_pkg::LABOE_RUN;
            acc_r <= `LABOE_ACC_RST;
            flags_r <= '0;
            fwr_r <= '0;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            flags_r <= flags_nxt;
            fwr_r <= fwr_nxt;
        end
    end

    assign acc = acc_r;
    assign flags = flags_r;
    assign freg_wr = fwr_r;
    assign freg_raddr = faddr;
    assign skip_active = (state_r == laboe_pkg::LABOE_FLUSH);
    assign instr_done = instr_valid;

    // checks look at registered outputs one edge after the decode
    chk_lit_add_sum: assert property (@(posedge clk) disable iff (!rst_n)
        is_lit_add |=> acc == $past(acc_r + lit))
        else $error("literal add result wrong");
    chk_lit_add_nowr: assert property (@(posedge clk) disable iff (!rst_n)
        is_lit_add |=> !freg_wr.we)
        else $error("literal add wrote a file register");
    chk_lit_and_flags: assert property (@(posedge clk) disable iff (!rst_n)
        is_lit_and |=> acc == $past(acc_r & lit) && flags.arith_overflow_bit ==
        $past(flags_r.arith_overflow_bit) && flags.null_result_bit == (acc == 8'h00))
        else $error("literal and wrong");
    chk_lit_and_nibble: assert property (@(posedge clk) disable iff (!rst_n)
        is_lit_and |=> flags.nibble_overflow_bit == $past(flags_r.nibble_overflow_bit)
        && !freg_wr.we)
        else $error("literal and touched other state");
    chk_reg_and_null: assert property (@(posedge clk) disable iff (!rst_n)
        is_reg_and |=> flags.null_result_bit == $past(and_reg == 8'h00)
        && flags.nibble_overflow_bit == $past(flags_r.nibble_overflow_bit))
        else $error("register and flag wrong");
    chk_reg_and_carry: assert property (@(posedge clk) disable iff (!rst_n)
        is_reg_and |=> flags.arith_overflow_bit == $past(flags_r.arith_overflow_bit))
        else $error("register and changed carry");
    // d=1 must leave the accumulator alone, d=0 must not write the file
    chk_dest_route: assert property (@(posedge clk) disable iff (!rst_n)
        (is_reg_add || is_reg_and) |=> freg_wr.we == $past(dest_f)
        && ($past(dest_f) ? $stable(acc)
        : acc == $past(is_reg_add ? acc_r + freg_rdata : acc_r & freg_rdata)))
        else $error("destination routing wrong");
    chk_dest_file: assert property (@(posedge clk) disable iff (!rst_n)
        (is_reg_add || is_reg_and) && dest_f |=> freg_wr.addr == $past(faddr)
        && freg_wr.data == $past(is_reg_add ? acc_r + freg_rdata : acc_r & freg_rdata))
        else $error("file write wrong");
    chk_reg_add_flags: assert property (@(posedge clk) disable iff (!rst_n)
        is_reg_add |=> flags.arith_overflow_bit ==
        ($past({1'b0, acc_r} + {1'b0, freg_rdata}) > 9'h0ff)
        && flags.null_result_bit == ($past(acc_r + freg_rdata) == 8'h00))
        else $error("register add flags wrong");
    chk_reg_add_nibble: assert property (@(posedge clk) disable iff (!rst_n)
        is_reg_add |=> flags.nibble_overflow_bit ==
        ($past({1'b0, acc_r[3:0]}) + $past({1'b0, freg_rdata[3:0]}) > 5'h0f))
        else $error("register add nibble carry wrong");
    chk_bclr_bit: assert property (@(posedge clk) disable iff (!rst_n)
        is_bclr |=> freg_wr.we && freg_wr.data == ($past(freg_rdata) & ~$past(bmask))
        && $stable(flags))
        else $error("bit clear wrong");
    chk_btst_flags: assert property (@(posedge clk) disable iff (!rst_n)
        is_btst |=> $stable(flags) && $stable(acc) && !freg_wr.we)
        else $error("bit test changed state");
    chk_skip_flush: assert property (@(posedge clk) disable iff (!rst_n)
        take_skip |=> skip_active ##1 !skip_active)
        else $error("skip not a single flush cycle");
    chk_noskip_run: assert property (@(posedge clk) disable iff (!rst_n)
        (is_btst && !take_skip) |=> !skip_active)
        else $error("spurious skip");
    chk_flush_inert: assert property (@(posedge clk) disable iff (!rst_n)
        skip_active |=> $stable(acc) && $stable(flags) && !freg_wr.we)
        else $error("flushed word executed");
    chk_carry_bits: assert property (@(posedge clk) disable iff (!rst_n)
        is_lit_add |=> flags.arith_overflow_bit ==
        ($past({1'b0, acc_r} + {1'b0, lit}) > 9'h0ff)
        && flags.nibble_overflow_bit == ($past(acc_r[3:0]) + $past(lit[3:0]) > 5'h0f))
        else $error("carry flags wrong");
    chk_lit_add_null: assert property (@(posedge clk) disable iff (!rst_n)
        is_lit_add |=> flags.null_result_bit == (acc == 8'h00))
        else $error("literal add null flag wrong");
    chk_bclr_others: assert property (@(posedge clk) disable iff (!rst_n)
        is_bclr |=> freg_wr.addr == $past(faddr) && $stable(acc)
        && (freg_wr.data | $past(bmask)) == ($past(freg_rdata) | $past(bmask)))
        else $error("bit clear disturbed other bits");
    chk_btst_skip_bit: assert property (@(posedge clk) disable iff (!rst_n)
        is_btst |=> skip_active == !$past(freg_rdata[bsel]))
        else $error("bit test skip decision wrong");
    chk_skip_cause: assert property (@(posedge clk) disable iff (!rst_n)
        skip_active |-> $past(take_skip))
        else $error("flush without a taken skip");
    chk_flush_once: assert property (@(posedge clk) disable iff (!rst_n)
        skip_active |=> !skip_active)
        else $error("flush longer than one cycle");
    // only the decoded ops may touch state; unknown words stay inert
    chk_wr_source: assert property (@(posedge clk) disable iff (!rst_n)
        freg_wr.we |-> $past(is_reg_add || is_reg_and || is_bclr))
        else $error("file write without a writing op");
    chk_acc_source: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(acc) |-> $past(is_lit_add || is_lit_and || is_reg_add || is_reg_and))
        else $error("accumulator changed without an op");
    chk_flags_source: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(flags) |-> $past(is_lit_add || is_lit_and || is_reg_add || is_reg_and))
        else $error("flags changed without an op");
    // reset leaves nothing half done, so the first word may follow at once
    chk_reset_state: assert property (@(posedge clk)
        !rst_n |=> !skip_active && !freg_wr.we && acc == `LABOE_ACC_RST && flags == '0)
        else $error("reset state wrong");

    // main scenarios
    cov_skip: cover property (@(posedge clk) disable iff (!rst_n) take_skip ##1 skip_active);
    cov_reg_add_f: cover property (@(posedge clk) disable iff (!rst_n) is_reg_add && dest_f);
    cov_carry: cover property (@(posedge clk) disable iff (!rst_n) is_lit_add && sum_lit[9]);
    cov_bclr: cover property (@(posedge clk) disable iff (!rst_n) is_bclr);
    cov_btst_run: cover property (@(posedge clk) disable iff (!rst_n) is_btst && !take_skip);
endmodule : laboe_exec

// file: testbench/literal_and_bit_op_exec_test.sv
// self-checking bench for the literal/bit execute unit
// assumes: bench plays the core; file reads come from freg_rdata, fixed in the directed steps and random in the loop
`timescale 1ns/1ps
`include "laboe_params.svh"
module literal_and_bit_op_exec_test;
    logic clk, rst_n, instr_valid, skip_active, instr_done, e_skip;
    logic [13:0] instr;
    logic [7:0] freg_rdata, acc, e_acc;
    logic [6:0] freg_raddr;
    logic [31:0] r;
    laboe_pkg::laboe_flags_t flags, e_flg;
    laboe_pkg::laboe_fwrite_t freg_wr, e_wr;
    int error_cnt, cmp_count;
    logic [13:0] ops [8] = '{14'h3e00, 14'h3900, 14'h0700, 14'h0500,
        14'h1000, 14'h1800, 14'h1400, 14'h0000};
    laboe_exec uut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .freg_rdata(freg_rdata), .acc(acc), .flags(flags), .freg_wr(freg_wr),
        .freg_raddr(freg_raddr), .skip_active(skip_active), .instr_done(instr_done));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic laboe_pkg::laboe_flags_t add_flags(input logic [7:0] a, b);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {s[8], n[4], s[7:0] == 8'h00};
    endfunction : add_flags
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic step(input logic v, input logic [13:0] w, input logic [7:0] rd);
        logic [7:0] res;
        @(negedge clk);
        check({8'h00, acc}, {8'h00, e_acc});
        check({13'h0000, flags}, {13'h0000, e_flg});
        check(freg_wr.we ? freg_wr : 16'h0000, e_wr);
        check({15'h0000, skip_active}, {15'h0000, e_skip});
        instr_valid = v;
        instr = w;
        freg_rdata = rd;
        #1;
        check({9'h000, freg_raddr}, {9'h000, w[6:0]});
        check({15'h0000, instr_done}, {15'h0000, v});
        e_wr = 16'h0000;
        if (v && !e_skip) begin
            res = (w[13:8] == `LABOE_ADD_REG_6) ? e_acc + rd : e_acc & rd;
            if (w[13:9] == `LABOE_ADD_LIT_5) begin
                e_flg = add_flags(e_acc, w[7:0]);
                e_acc = e_acc + w[7:0];
            end else if (w[13:8] == `LABOE_AND_LIT_6) begin
                e_acc = e_acc & w[7:0];
                e_flg.null_result_bit = (e_acc == 8'h00);
            end else if (w[13:8] == `LABOE_ADD_REG_6 || w[13:8] == `LABOE_AND_REG_6) begin
                if (w[13:8] == `LABOE_ADD_REG_6) e_flg = add_flags(e_acc, rd);
                e_flg.null_result_bit = (res == 8'h00);
                if (w[7]) e_wr = {1'b1, w[6:0], res};
                else e_acc = res;
            end else if (w[13:10] == `LABOE_BCLR_4) begin
                e_wr = {1'b1, w[6:0], rd & ~(8'h01 << w[9:7])};
            end
            e_skip = (w[13:10] == `LABOE_BTST_4) && !rd[w[9:7]];
        end else e_skip = 1'b0;
    endtask : step
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        r = 32'd79865;
        {rst_n, instr_valid, instr, freg_rdata} = '0;
        {e_acc, e_flg, e_wr, e_skip} = '0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        step(1'b0, 14'h0000, 8'h00);
        step(1'b1, 14'h3900, 8'h00);
        step(1'b1, 14'h3e10, 8'h00);
        step(1'b1, 14'h3e15, 8'h00);
        step(1'b1, 14'h3fdb, 8'h00);
        step(1'b1, 14'h1b85, 8'h7f);
        step(1'b1, 14'h3e01, 8'h00);
        step(1'b1, 14'h1385, 8'hc7);
        step(1'b1, 14'h0785, 8'h17);
        step(1'b1, 14'h0505, 8'hc2);
        $display("test directed done");
        for (int i = 0; i < 2000; i++) begin
            r = lfsr_next(r);
            step(r[20:18] != 3'h0, ops[r[2:0]] | (r[16:3] & (r[2] ? 14'h03ff : 14'h00ff)),
                r[31:24]);
        end
        step(1'b0, 14'h0000, 8'h00);
        $display("test random done");
        print_verdict();
    end
endmodule : literal_and_bit_op_exec_test
